// ### rtl/tcc_byte_counter.sv
// One byte of the timer count, with software load and wrap indication.
`default_nettype none

module tcc_byte_counter
  import tcc_pkg::*;
#(
  parameter int unsigned WIDTH = BYTE_W
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // Control
  input  wire logic             countEnable,
  input  wire logic             loadEnable,
  input  wire logic [WIDTH-1:0] loadValue,
  // Status
  output logic      [WIDTH-1:0] count,
  output logic                  wrap
);

  localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  // A software load replaces the increment of that cycle and reports no wrap.
  always_comb begin
    count_next = count_reg;
    if (loadEnable) begin
      count_next = loadValue;
    end else if (countEnable) begin
      count_next = count_reg + ONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;
  assign wrap  = countEnable && !loadEnable && (count_reg == {WIDTH{1'b1}});

endmodule : tcc_byte_counter

`default_nettype wire

// ### rtl/tcc_event_sync.sv
// Synchroniser and rising-edge pulse former for the capture event inputs.
`default_nettype none

module tcc_event_sync
  import tcc_pkg::*;
#(
  parameter int unsigned N = SRC_N
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // Events
  input  wire logic [N-1:0] eventRaw,
  output logic      [N-1:0] eventPulse
);

  logic [N-1:0] meta_reg;
  logic [N-1:0] meta_next;
  logic [N-1:0] sync_reg;
  logic [N-1:0] sync_next;
  logic [N-1:0] last_reg;
  logic [N-1:0] last_next;

  // The first stage feeds only the second; edges are taken after it.
  always_comb begin
    meta_next = eventRaw;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_edge
      assign eventPulse[i] = sync_reg[i] & ~last_reg[i]; // RL17
    end
  endgenerate

  a_pulse_single: assert property (@(posedge clk_sys) disable iff (!nrst) // RL17
    (|eventPulse) |=> ((eventPulse & $past(eventPulse)) == '0))
    else $error("capture pulse lasted more than one cycle");

endmodule : tcc_event_sync

`default_nettype wire

// ### rtl/tcc_pkg.sv
// Shared constants and types of the timer capture and calibration block.
`default_nettype none

package tcc_pkg;

  // Bus geometry; register indices, byte address is four times the index.
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned IDX_W        = ADDR_W - 2;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned BYTE_W       = 8;
  localparam logic [IDX_W-1:0] IDX_CTRL     = 10'h091;
  localparam logic [IDX_W-1:0] IDX_CNT_LO   = 10'h092;
  localparam logic [IDX_W-1:0] IDX_CNT_HI   = 10'h093;
  localparam logic [IDX_W-1:0] IDX_RLD_LO   = 10'h094;
  localparam logic [IDX_W-1:0] IDX_RLD_HI   = 10'h095;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h096;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h097;

  // Reset values and counter limits.
  localparam logic [BYTE_W-1:0] CTRL_RESET  = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_ZERO   = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_MAX    = 8'hFF;
  localparam logic [15:0]       WORD_MAX    = 16'hFFFF;
  localparam logic [15:0]       WORD_ZERO   = 16'h0000;

  // Interrupt status and mask layout.
  localparam int unsigned IRQ_W   = 3;
  localparam int unsigned IRQ_HI  = 0;
  localparam int unsigned IRQ_LO  = 1;
  localparam int unsigned IRQ_CAP = 2;
  localparam logic [IRQ_W-1:0] IRQ_ZERO    = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_LO_ONLY = 3'h2;

  // Capture event sources, also the index into the synchroniser.
  localparam int unsigned SRC_SOF = 0;
  localparam int unsigned SRC_LFO = 1;
  localparam int unsigned SRC_N   = 2;

  // Byte positions of the 16-bit count.
  localparam int unsigned LO = 0;
  localparam int unsigned HI = 1;

  // Timer control register, bit 7 first.
  typedef struct packed {
    logic hiOverflowFlag;
    logic loOverflowFlag;
    logic loOverflowIrqEnable;
    logic captureEnable;
    logic splitModeEnable;
    logic runControl;
    logic captureSourceSelect;
    logic extClockSelect;
  } tcc_ctrl_type;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0]        pstrb;
  } tcc_apb_req_type;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } tcc_apb_rsp_type;

  localparam tcc_apb_rsp_type APB_RSP_RESET = '{prdata: 32'h00000000, pready: 1'b0,
                                                pslverr: 1'b0};

endpackage : tcc_pkg

`default_nettype wire

// ### rtl/tcc_timer_capture.sv
// Top of the timer capture block: counters, capture, flags, interrupt and APB slave.
// Behaviour
// [RL1] Capture enable set puts timer in capture
// [RL2] Source select: 0 frame start, 1 oscillator
// [RL3] Unsplit: one 16-bit counter wrapping to zero
// [RL4] Capture copies whole 16-bit count to reloads
// [RL5] Capture raises timer interrupt when enabled
// [RL6] Split: two independent wrapping byte counters
// [RL7] Split capture copies both bytes at once
// [RL8] High byte wrap sets high overflow flag
// [RL9] Set high flag interrupts when enabled
// [RL10] Software alone clears the high flag
// [RL11] Low byte wrap always sets low flag
// [RL12] Low interrupt needs low enable and timer enable
// [RL13] Software keeps low enable off unsplit
// [RL14] Capture enable zero disables capture entirely
// [RL15] Control register resets to all zeros
// [RL16] Run gates whole timer; split gates high
// [RL17] Events synchronised into single-cycle capture pulses
//
// The implementer's own choice: the APB interface to the registers.
`default_nettype none

module tcc_timer_capture
  import tcc_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            nrst,
  // Register bus
  input  wire tcc_apb_req_type apbReq,
  output tcc_apb_rsp_type      apbRsp,
  // Capture event inputs, asynchronous
  input  wire logic            sofEvent,
  input  wire logic            lowFreqOsc,
  // Interrupt
  output logic                 timerIrq
);

  tcc_ctrl_type              ctrl_reg;
  tcc_ctrl_type              ctrl_next;
  logic [BYTE_W-1:0]         reloadLow_reg;
  logic [BYTE_W-1:0]         reloadLow_next;
  logic [BYTE_W-1:0]         reloadHigh_reg;
  logic [BYTE_W-1:0]         reloadHigh_next;
  logic [IRQ_W-1:0]          irqStatus_reg;
  logic [IRQ_W-1:0]          irqStatus_next;
  logic [IRQ_W-1:0]          irqMask_reg;
  logic [IRQ_W-1:0]          irqMask_next;
  logic                      irq_reg;
  logic                      irq_next;
  tcc_apb_rsp_type           apbRsp_reg;
  tcc_apb_rsp_type           apbRsp_next;

  logic [SRC_N-1:0]          eventPulse;
  logic [1:0]                countEnable;
  logic [1:0]                countLoad;
  logic [1:0]                countWrap;
  logic [BYTE_W-1:0]         countByte [2];
  logic [15:0]               countWord;
  logic [15:0]               reloadWord;
  logic                      selectedEvent;
  logic                      captureStrobe;
  logic [IRQ_W-1:0]          irqEvents;
  logic [IRQ_W-1:0]          irqGate;

  logic                      accessPhase;
  logic                      commit;
  logic                      swWrite;
  logic                      mapped;
  logic [IDX_W-1:0]          regIndex;
  logic [BYTE_W-1:0]         wrByte;
  logic [BYTE_W-1:0]         rdByte;

  // Capture event inputs.

  tcc_event_sync #(
    .N (SRC_N)
  ) u_event_sync (
    .clk_sys    (clk_sys),
    .nrst       (nrst),
    .eventRaw   ({lowFreqOsc, sofEvent}),
    .eventPulse (eventPulse)
  );

  always_comb begin
    selectedEvent = ctrl_reg.captureSourceSelect ? eventPulse[SRC_LFO]  // RL2
                                                 : eventPulse[SRC_SOF];
    captureStrobe = ctrl_reg.captureEnable && selectedEvent; // RL1 RL14
  end

  // Counting. In split mode the low byte ignores run control so that it can
  // keep measuring while software stops only the high byte.

  always_comb begin
    if (ctrl_reg.splitModeEnable) begin
      countEnable[LO] = 1'b1; // RL16
      countEnable[HI] = ctrl_reg.runControl; // RL6
    end else begin
      countEnable[LO] = ctrl_reg.runControl; // RL16
      countEnable[HI] = ctrl_reg.runControl && countWrap[LO]; // RL3
    end
  end

  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_byte
      assign countLoad[b] = swWrite && (regIndex == (b == LO ? IDX_CNT_LO : IDX_CNT_HI));
      tcc_byte_counter #(
        .WIDTH (BYTE_W)
      ) u_counter (
        .clk_sys     (clk_sys),
        .nrst        (nrst),
        .countEnable (countEnable[b]),
        .loadEnable  (countLoad[b]),
        .loadValue   (wrByte),
        .count       (countByte[b]),
        .wrap        (countWrap[b])
      );
    end
  endgenerate

  assign countWord  = {countByte[HI], countByte[LO]};
  assign reloadWord = {reloadHigh_reg, reloadLow_reg};

  // Register bus. Every access takes one wait state so that read data and
  // the answer leave from flip-flops; writes land on the completing edge.

  always_comb begin
    accessPhase = apbReq.psel && apbReq.penable;
    commit      = accessPhase && apbRsp_reg.pready;
    regIndex    = apbReq.paddr[ADDR_W-1:2];
    wrByte      = apbReq.pwdata[BYTE_W-1:0];
    mapped      = 1'b0;
    rdByte      = BYTE_ZERO;
    if (apbReq.paddr[1:0] == 2'b00) begin
      mapped = 1'b1;
      case (regIndex)
        IDX_CTRL:     rdByte = ctrl_reg;
        IDX_CNT_LO:   rdByte = countByte[LO];
        IDX_CNT_HI:   rdByte = countByte[HI];
        IDX_RLD_LO:   rdByte = reloadLow_reg;
        IDX_RLD_HI:   rdByte = reloadHigh_reg;
        IDX_IRQ_STAT: rdByte = {{(BYTE_W-IRQ_W){1'b0}}, irqStatus_reg};
        IDX_IRQ_MASK: rdByte = {{(BYTE_W-IRQ_W){1'b0}}, irqMask_reg};
        default:      mapped = 1'b0;
      endcase
    end
    swWrite = commit && apbReq.pwrite && apbReq.pstrb[0] && mapped;
  end

  always_comb begin
    apbRsp_next = APB_RSP_RESET;
    if (accessPhase && !apbRsp_reg.pready) begin
      apbRsp_next.pready  = 1'b1;
      apbRsp_next.pslverr = !mapped;
      if (!apbReq.pwrite) begin
        apbRsp_next.prdata = {{(DATA_W-BYTE_W){1'b0}}, rdByte};
      end
    end
  end

  // Control register: hardware sets of the flags win over a software write.

  always_comb begin
    ctrl_next = ctrl_reg;
    if (swWrite && regIndex == IDX_CTRL) begin
      ctrl_next = tcc_ctrl_type'(wrByte);
    end
    if (countWrap[HI]) begin
      ctrl_next.hiOverflowFlag = 1'b1; // RL8
    end
    if (countWrap[LO]) begin
      ctrl_next.loOverflowFlag = 1'b1; // RL11
    end
  end

  // Reload bytes: a capture beats a software write in the same cycle.

  always_comb begin
    reloadLow_next  = reloadLow_reg;
    reloadHigh_next = reloadHigh_reg;
    if (captureStrobe) begin
      reloadLow_next  = countByte[LO]; // RL7
      reloadHigh_next = countByte[HI]; // RL4
    end else begin
      if (swWrite && regIndex == IDX_RLD_LO) begin
        reloadLow_next = wrByte;
      end
      if (swWrite && regIndex == IDX_RLD_HI) begin
        reloadHigh_next = wrByte;
      end
    end
  end

  // Interrupt status is write-one-to-clear; new events win over the clear.
  // The mask acts as the timer interrupt enable per source.

  always_comb begin
    irqEvents          = IRQ_ZERO;
    irqEvents[IRQ_HI]  = countWrap[HI];
    irqEvents[IRQ_LO]  = countWrap[LO];
    irqEvents[IRQ_CAP] = captureStrobe; // RL5
    irqGate            = {IRQ_W{1'b1}};
    irqGate[IRQ_LO]    = ctrl_reg.loOverflowIrqEnable; // RL12
    irqStatus_next     = irqStatus_reg;
    irqMask_next       = irqMask_reg;
    if (swWrite && regIndex == IDX_IRQ_STAT) begin
      irqStatus_next = irqStatus_reg & ~wrByte[IRQ_W-1:0];
    end
    if (swWrite && regIndex == IDX_IRQ_MASK) begin
      irqMask_next = wrByte[IRQ_W-1:0];
    end
    irqStatus_next = irqStatus_next | irqEvents;
    irq_next       = |(irqStatus_reg & irqMask_reg & irqGate); // RL9
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl_reg       <= tcc_ctrl_type'(CTRL_RESET); // RL15
      reloadLow_reg  <= BYTE_ZERO;
      reloadHigh_reg <= BYTE_ZERO;
      irqStatus_reg  <= IRQ_ZERO;
      irqMask_reg    <= IRQ_ZERO;
      irq_reg        <= 1'b0;
      apbRsp_reg     <= APB_RSP_RESET;
    end else begin
      ctrl_reg       <= ctrl_next;
      reloadLow_reg  <= reloadLow_next;
      reloadHigh_reg <= reloadHigh_next;
      irqStatus_reg  <= irqStatus_next;
      irqMask_reg    <= irqMask_next;
      irq_reg        <= irq_next;
      apbRsp_reg     <= apbRsp_next;
    end
  end

  assign apbRsp   = apbRsp_reg;
  assign timerIrq = irq_reg;

  // Checks.

  a_lfo_only: assert property (@(posedge clk_sys) disable iff (!nrst) // RL1
    (ctrl_reg.captureEnable && ctrl_reg.captureSourceSelect && !eventPulse[SRC_LFO]
      && !swWrite) |=> $stable(reloadWord))
    else $error("reloads changed without the selected oscillator edge");

  a_sof_capture: assert property (@(posedge clk_sys) disable iff (!nrst) // RL2
    (ctrl_reg.captureEnable && !ctrl_reg.captureSourceSelect && eventPulse[SRC_SOF])
      |=> (reloadWord == $past(countWord)))
    else $error("frame start event did not capture the count");

  a_wide_wrap: assert property (@(posedge clk_sys) disable iff (!nrst) // RL3
    (!ctrl_reg.splitModeEnable && ctrl_reg.runControl && countWord == WORD_MAX && !swWrite)
      |=> (countWord == WORD_ZERO))
    else $error("16-bit count did not wrap to zero");

  a_capture_copy: assert property (@(posedge clk_sys) disable iff (!nrst) // RL4
    (captureStrobe && !ctrl_reg.splitModeEnable) |=> (reloadWord == $past(countWord)))
    else $error("16-bit capture did not copy the count");

  a_irq_capture: assert property (@(posedge clk_sys) disable iff (!nrst) // RL5
    (captureStrobe && irqMask_reg[IRQ_CAP] && !apbReq.psel) |-> ##2 timerIrq)
    else $error("capture did not raise the interrupt two cycles later");

  a_split_lo_step: assert property (@(posedge clk_sys) disable iff (!nrst) // RL6
    (ctrl_reg.splitModeEnable && !swWrite)
      |=> (countByte[LO] == $past(countByte[LO]) + 8'h01))
    else $error("split low byte did not count on");

  a_split_copy: assert property (@(posedge clk_sys) disable iff (!nrst) // RL7
    (captureStrobe && ctrl_reg.splitModeEnable) |=> (reloadWord == $past(countWord)))
    else $error("split capture did not copy both bytes");

  a_hi_flag_set: assert property (@(posedge clk_sys) disable iff (!nrst) // RL8
    countWrap[HI] |=> ctrl_reg.hiOverflowFlag)
    else $error("high byte wrap did not set the high flag");

  a_hi_irq: assert property (@(posedge clk_sys) disable iff (!nrst) // RL9
    (countWrap[HI] && irqMask_reg[IRQ_HI] && !apbReq.psel) |-> ##2 timerIrq)
    else $error("high overflow did not raise the interrupt");

  a_hi_flag_hold: assert property (@(posedge clk_sys) disable iff (!nrst) // RL10
    (ctrl_reg.hiOverflowFlag && !swWrite) |=> ctrl_reg.hiOverflowFlag)
    else $error("high flag cleared without software");

  a_lo_flag_set: assert property (@(posedge clk_sys) disable iff (!nrst) // RL11
    countWrap[LO] |=> ctrl_reg.loOverflowFlag)
    else $error("low byte wrap did not set the low flag");

  a_lo_irq_gate: assert property (@(posedge clk_sys) disable iff (!nrst) // RL12
    (irqStatus_reg == IRQ_LO_ONLY && !ctrl_reg.loOverflowIrqEnable) |=> !timerIrq)
    else $error("low overflow interrupted while its enable is clear");

  a_capture_off: assert property (@(posedge clk_sys) disable iff (!nrst) // RL14
    (!ctrl_reg.captureEnable && !swWrite) |=> $stable(reloadWord))
    else $error("reload bytes changed while capture is disabled");

  a_ctrl_reset: assert property (@(posedge clk_sys) // RL15
    !nrst |=> (ctrl_reg == tcc_ctrl_type'(CTRL_RESET)))
    else $error("control register not cleared by reset");

  a_run_hold: assert property (@(posedge clk_sys) disable iff (!nrst) // RL16
    (!ctrl_reg.splitModeEnable && !ctrl_reg.runControl && !swWrite) |=> $stable(countWord))
    else $error("16-bit count moved while stopped");

endmodule : tcc_timer_capture

`default_nettype wire

// ### verif/tcc_event_source.sv
// Model of the frame-start detector and the oscillator edge that feed the timer.
`default_nettype none

module tcc_event_source
  import tcc_pkg::*;
(
  // Clock
  input  wire logic             clk_sys,
  // Commands from the bench, one bit per source
  input  wire logic [SRC_N-1:0] fire,
  // Event lines
  output logic                  sofEvent,
  output logic                  lowFreqOsc
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] holdCnt [SRC_N] = '{default: 3'h0};

  // Each level is held four cycles so that the two-flop synchroniser cannot miss it.
  always @(posedge clk_sys) begin
    for (int s = 0; s < SRC_N; s++) begin
      if (fire[s] && holdCnt[s] == 3'h0) begin
        holdCnt[s] <= 3'h4;
      end else if (holdCnt[s] != 3'h0) begin
        holdCnt[s] <= holdCnt[s] - 3'h1;
      end
    end
  end

  assign sofEvent   = holdCnt[SRC_SOF] != 3'h0;
  assign lowFreqOsc = holdCnt[SRC_LFO] != 3'h0;

endmodule : tcc_event_source

`default_nettype wire

// ### verif/test_tcc_timer_capture.sv
// Self-checking bench of the timer capture block.
`default_nettype none

module test_tcc_timer_capture
  import tcc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic             clk_sys;
  logic             nrst   = 1'b0;
  tcc_apb_req_type  apbReq = '0;
  tcc_apb_rsp_type  apbRsp;
  logic [SRC_N-1:0] fire   = '0;
  logic             sofEvent;
  logic             lowFreqOsc;
  logic             timerIrq;
  logic [31:0]      rd;
  logic             er;
  logic [15:0]      v;
  logic [7:0]       prevLo;
  int               n_fail = 0;
  int               checks = 0;
  int               cycles = 0;

  tcc_timer_capture tcc_timer_capture_inst (
    .clk_sys    (clk_sys),
    .nrst       (nrst),
    .apbReq     (apbReq),
    .apbRsp     (apbRsp),
    .sofEvent   (sofEvent),
    .lowFreqOsc (lowFreqOsc),
    .timerIrq   (timerIrq)
  );

  tcc_event_source tcc_event_source_inst (
    .clk_sys    (clk_sys),
    .fire       (fire),
    .sofEvent   (sofEvent),
    .lowFreqOsc (lowFreqOsc)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  // The whole run needs about a thousand cycles; a stuck handshake ends it here.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // Low byte value n cycles on from base; it wraps within the byte.
  function automatic logic [31:0] lo_ahead(input logic [7:0] base, input int n);
    logic [7:0] s;
    s = base + 8'(n);
    return 32'(s);
  endfunction : lo_ahead

  task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd);
    @(posedge clk_sys);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00},
                pwdata: wd, pstrb: 4'hF};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do @(posedge clk_sys); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    er = apbRsp.pslverr;
    apbReq.psel    <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask : wr

  task automatic rdc(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h00000000);
    chk(rd, exp);
  endtask : rdc

  // The partner holds each event long enough; the wait lets the capture settle.
  task automatic ev(input int s);
    fire <= SRC_N'(1 << s);
    @(posedge clk_sys);
    fire <= '0;
    cyc(12);
  endtask : ev

  task automatic done(input int n);
    $display("test %0d done", n);
  endtask : done

  initial begin
    void'($urandom(93));
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = IDX_CTRL; i <= IDX_IRQ_MASK; i++) begin
      rdc(IDX_W'(i), 32'h00000000);
    end
    apb(1'b0, 10'h098, 32'h00000000);
    chk(32'(er), 32'h00000001);
    done(1);

    wr(IDX_IRQ_MASK, 32'h00000004);
    wr(IDX_CNT_LO, 32'h00000033);
    ev(SRC_SOF);
    rdc(IDX_RLD_LO, 32'h00000000);
    chk(32'(timerIrq), 32'h00000000);
    prevLo = 8'h00;
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 16'hFFFF : 16'($urandom);
      wr(IDX_CNT_LO, 32'(v[7:0]));
      wr(IDX_CNT_HI, 32'(v[15:8]));
      wr(IDX_CTRL, 32'h00000010 | 32'((i % 2) << 1));
      ev(1 - i % 2);
      rdc(IDX_RLD_LO, 32'(prevLo));
      ev(i % 2);
      rdc(IDX_RLD_LO, 32'(v[7:0]));
      rdc(IDX_RLD_HI, 32'(v[15:8]));
      chk(32'(timerIrq), 32'h00000001);
      wr(IDX_IRQ_STAT, 32'h00000004);
      cyc(2);
      chk(32'(timerIrq), 32'h00000000);
      prevLo = v[7:0];
    end
    done(2);

    wr(IDX_CNT_HI, 32'h0000005A);
    wr(IDX_CTRL, 32'h00000018);
    ev(SRC_SOF);
    rdc(IDX_RLD_HI, 32'h0000005A);
    rdc(IDX_CNT_HI, 32'h0000005A);
    apb(1'b0, IDX_CNT_LO, 32'h00000000);
    v[7:0] = rd[7:0];
    apb(1'b0, IDX_CNT_LO, 32'h00000000);
    // Read data of two back-to-back access tasks are taken four cycles apart.
    chk(rd, lo_ahead(v[7:0], 4));
    done(3);

    wr(IDX_CNT_LO, 32'h00000000);
    wr(IDX_CTRL, 32'h00000008);
    wr(IDX_IRQ_STAT, 32'h00000007);
    wr(IDX_IRQ_MASK, 32'h00000002);
    cyc(300);
    chk(32'(timerIrq), 32'h00000000);
    rdc(IDX_CTRL, 32'h00000048);
    wr(IDX_CTRL, 32'h00000068);
    cyc(2);
    chk(32'(timerIrq), 32'h00000001);
    done(4);

    wr(IDX_CTRL, 32'h00000000);
    wr(IDX_IRQ_STAT, 32'h00000007);
    wr(IDX_IRQ_MASK, 32'h00000001);
    wr(IDX_CNT_HI, 32'h000000FF);
    wr(IDX_CNT_LO, 32'h000000F0);
    wr(IDX_CTRL, 32'h00000004);
    cyc(40);
    rdc(IDX_CNT_HI, 32'h00000000);
    rdc(IDX_CTRL, 32'h000000C4);
    chk(32'(timerIrq), 32'h00000001);
    cyc(100);
    rdc(IDX_CTRL, 32'h000000C4);
    wr(IDX_CTRL, 32'h00000004);
    rdc(IDX_CTRL, 32'h00000004);
    done(5);

    nrst <= 1'b0;
    cyc(2);
    nrst <= 1'b1;
    rdc(IDX_CTRL, 32'h00000000);
    rdc(IDX_IRQ_STAT, 32'h00000000);
    chk(32'(timerIrq), 32'h00000000);
    done(6);
    summarize();
  end

endmodule : test_tcc_timer_capture

`default_nettype wire
